// ---- logic/ssc_pkg.sv ----
// shared constants and types for the sync and strap configuration block
package ssc_pkg;
   // strap decode table entry
   typedef struct packed {
      logic [8:0] decimation;   // decimation rate
      logic       low_power;    // 1 = low power mode
      logic       gain4_hi;     // channels 4..7 at gain 4
      logic       int_ref;      // 1 = internal reference
      logic       sinc5;        // 1 = fifth-order filter
   } ssc_cfg_type;

   // lane layout codes
   typedef enum logic [1:0] {
      SSC_LANES_SPI = 2'h0,
      SSC_LANES_4   = 2'h1,
      SSC_LANES_2   = 2'h2,
      SSC_LANES_1   = 2'h3
   } ssc_lanes_type;

   // base rates and maximum output rates in kHz
   localparam logic [11:0] SSC_HR_BASE_KHZ  = 12'h0800;  // 2048
   localparam logic [11:0] SSC_LP_BASE_KHZ  = 12'h0200;  // 512
   localparam logic [11:0] SSC_HR_NOTCH_KHZ = 12'h0080;  // 128
   localparam logic [11:0] SSC_LP_NOTCH_KHZ = 12'h0020;  // 32
   localparam int          SSC_SINC5_REC_KSPS = 24;      // advisory only

   // host register map (apb byte offsets)
   localparam logic [11:0] SSC_REG_CTRL   = 12'h000;  // w: bit0 restart trigger
   localparam logic [11:0] SSC_REG_STRAP  = 12'h004;  // rw: strap levels
   localparam logic [11:0] SSC_REG_STATUS = 12'h008;  // r: pulse count
   localparam int          SSC_CTRL_TRIG_BIT = 0;

   // strap register fields
   localparam int SSC_ST_MODE_LSB = 0;   // 4 config strap bits
   localparam int SSC_ST_FMT_LSB  = 4;   // 2 format bits
   localparam int SSC_ST_AUX_BIT  = 6;
   localparam int SSC_ST_DIV_LSB  = 7;   // 3 divider bits
   localparam logic [9:0] SSC_STRAP_RST = 10'h000;

   // device control: bit 0 of second user setup register
   localparam int SSC_UCFG2_SYNC_BIT = 0;
endpackage : ssc_pkg

// ---- logic/ssc_if.sv ----
// link between the converter device end and the host end
`timescale 1ns/1ps
interface ssc_if;
   logic       start_async;    // asynchronous start input
   logic       sync_restart;   // filter restart input
   logic       sync_aligned;   // aligned pulse output
   logic [3:0] config_strap;   // config_strap_bit3..0
   logic       iface_format_strap_lo;
   logic       iface_format_strap_hi;
   logic       aux_convert_strap;
   logic [2:0] divider_strap;  // divider_strap_bit2..0
   // device end
   modport dev (
      input  start_async, sync_restart, config_strap, iface_format_strap_lo,
             iface_format_strap_hi, aux_convert_strap, divider_strap,
      output sync_aligned
   );
   // host end
   modport host (
      output start_async, sync_restart, config_strap, iface_format_strap_lo,
             iface_format_strap_hi, aux_convert_strap, divider_strap,
      input  sync_aligned
   );
endinterface : ssc_if

// ---- logic/ssc_device.sv ----
// converter device end: start resync, restart pulse, strap decode
`timescale 1ns/1ps
// Functional notes
// RQ1 - restart clears filter path, keeps registers
// RQ2 - host restarts after filter register changes
// RQ3 - restart input pulse is master-clock synchronous
// RQ4 - start input resynchronised onto aligned output
// RQ5 - toggling setup bit 0 emits aligned pulse
// RQ6 - board ties aligned output to restart input
// RQ7 - shared restart needs a common master clock
// RQ8 - unused start input held low
// RQ9 - sinc3 notch at maximum output rate
// RQ10 - sinc5 notch at power-mode maximum rate
// RQ11 - sinc5 advised above 24 kSPS
// RQ12 - strap mode takes config from four straps
// RQ13 - output rate is 2048 or 512 over decimation
// RQ14 - upper channels gain 4 on odd low codes
// RQ15 - sixteen-entry decimation, reference and filter table
// RQ16 - format straps pick serial control or lanes
// RQ17 - divider straps pick power-of-two bit clock
// RQ18 - straps resampled on every restart pulse
// RQ19 - strap mode disables converter, diagnostics, errors; code gates only rate_converter_en and diag_en, no error output
// RQ20 - aligned pulse lasts exactly one cycle
module ssc_device (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // link
   ssc_if.dev                     link,
   // serial control side
   input  wire logic              ucfg2_wr,             // write strobe, second setup register
   input  wire logic [7:0]        ucfg2_wdata,          // write data
   // decoded configuration
   output logic                   filter_reset,         // one-cycle filter path reset
   output logic                   serial_ctrl,          // serial control mode active
   output ssc_pkg::ssc_cfg_type   cfg,                  // power/decimation/gain/ref/filter
   output logic [11:0]            output_word_rate,     // kHz
   output logic [11:0]            notch_max_khz,        // fixed notch frequency
   output logic [2:0]             notch_count,          // notches at output rate
   output ssc_pkg::ssc_lanes_type serial_data_lanes,
   output logic [7:0]             output_bit_clock_div,
   output logic                   rate_converter_en,
   output logic                   diag_en
);
   import ssc_pkg::*;

   // all state
   typedef struct packed {
      // start pin path
      logic [1:0]    start_sync;   // two-flop resync of start
      logic          start_prev;   // edge detect on synced start
      logic          trig_bit;     // last value of setup bit 0
      logic          aligned;      // aligned pulse
      // restart path
      logic [1:0]    restart_sync; // restart resync (input is other logic)
      logic          restart_prev;
      logic          filt_rst;
      // configuration sampled from the straps
      logic          serial;
      ssc_cfg_type   cfg;
      logic [11:0]   owr;
      logic [11:0]   notch;
      logic [2:0]    ncount;
      ssc_lanes_type lanes;
      logic [7:0]    bdiv;
      logic          loaded;       // straps caught after reset release
   } ssc_dev_state_type;

   ssc_dev_state_type s_q, s_d;

   // strap decode table
   function automatic ssc_cfg_type decode(input logic [3:0] c);
      ssc_cfg_type r;
      // defaults match code 0000
      r.decimation = 9'h010;
      r.low_power  = 1'b0;
      r.gain4_hi   = 1'b0;
      r.int_ref    = 1'b0;
      r.sinc5      = 1'b1;
      unique case (c) // [RQ15]
         // high resolution, external reference, fifth order
         4'h0, 4'h1: r.decimation = 9'h010;
         4'h2, 4'h3: r.decimation = 9'h020;
         4'h4, 4'h5: r.decimation = 9'h040;
         4'h6, 4'h7: r.decimation = 9'h080;
         4'h8:       r.decimation = 9'h100;
         // high resolution, internal reference
         4'h9: begin
            r.decimation = 9'h010;
            r.int_ref    = 1'b1;
         end
         4'hA: begin
            r.decimation = 9'h020;
            r.int_ref    = 1'b1;
         end
         4'hB: begin
            r.decimation = 9'h040;
            r.int_ref    = 1'b1;
         end
         // low power: fifth order first, then third order
         4'hC: begin
            r.decimation = 9'h010;
            r.low_power  = 1'b1;
         end
         4'hD: begin
            r.decimation = 9'h020;
            r.low_power  = 1'b1;
         end
         4'hE: begin
            r.decimation = 9'h040;
            r.low_power  = 1'b1;
            r.sinc5      = 1'b0;
         end
         4'hF: begin
            r.decimation = 9'h020;
            r.low_power  = 1'b1;
            r.sinc5      = 1'b0;
         end
      endcase
      // odd codes below eight put upper channels at gain 4
      r.gain4_hi = ~c[3] & c[0]; // [RQ14]
      return r;
   endfunction : decode

   // next state
   always_comb begin
      logic        start_edge;
      logic        trig_toggle;
      logic        restart_edge;
      logic [1:0]  fmt;
      ssc_cfg_type nc;
      // defaults: hold every register, events idle
      s_d          = s_q;
      start_edge   = 1'b0;
      trig_toggle  = 1'b0;
      restart_edge = 1'b0;
      fmt          = {link.iface_format_strap_hi, link.iface_format_strap_lo};
      nc           = decode(link.config_strap);
      // start: second flop only feeds the edge logic
      s_d.start_sync = {s_q.start_sync[0], link.start_async};  // [RQ4]
      s_d.start_prev = s_q.start_sync[1];
      start_edge     = s_q.start_sync[1] & ~s_q.start_prev;      // [RQ4]
      // register trigger counts only in serial control mode
      // rewriting the same bit value is no toggle, so no pulse
      if (ucfg2_wr) begin
         s_d.trig_bit = ucfg2_wdata[SSC_UCFG2_SYNC_BIT];
         trig_toggle  = s_q.serial & (ucfg2_wdata[SSC_UCFG2_SYNC_BIT] != s_q.trig_bit); // [RQ5]
      end
      // one pulse per event, never stretched
      s_d.aligned = start_edge | trig_toggle; // [RQ20]
      // restart is resynced defensively, though it should be synchronous
      s_d.restart_sync = {s_q.restart_sync[0], link.sync_restart}; // [RQ18]
      s_d.restart_prev = s_q.restart_sync[1];
      // edge detect keeps a held-high restart from firing twice
      restart_edge     = s_q.restart_sync[1] & ~s_q.restart_prev;
      // filter reset touches no register contents
      s_d.filt_rst = restart_edge; // [RQ1]
      // resample straps at power-up and on every restart
      if (restart_edge || !s_q.loaded) begin // [RQ18]
         s_d.loaded = 1'b1;
         s_d.serial = &fmt; // [RQ16]
         // power, decimation, gain, reference and filter from the table
         s_d.cfg    = nc;   // [RQ12]
         // rate = base / decimation (decimation is a power of two)
         s_d.owr    = (nc.low_power ? SSC_LP_BASE_KHZ : SSC_HR_BASE_KHZ)
                      / 12'(nc.decimation); // [RQ13]
         // one notch sits at the power mode's maximum rate
         s_d.notch  = nc.low_power ? SSC_LP_NOTCH_KHZ : SSC_HR_NOTCH_KHZ; // [RQ9] [RQ10]
         // notches at the chosen rate: four for sinc5, two for sinc3
         s_d.ncount = nc.sinc5 ? 3'h4 : 3'h2; // [RQ9] [RQ10]
         // aux strap high or serial control: data leave on the serial port
         if (link.aux_convert_strap || (&fmt))
            s_d.lanes = SSC_LANES_SPI; // [RQ16]
         else begin
            // lane count from the two format straps
            unique case (fmt)
               2'b00:   s_d.lanes = SSC_LANES_4;
               2'b01:   s_d.lanes = SSC_LANES_2;
               default: s_d.lanes = SSC_LANES_1;
            endcase
         end
         // bit clock divider is a power of two, 1 to 128
         s_d.bdiv = 8'h01 << link.divider_strap; // [RQ17]
      end
   end

   // state register
   // async reset clears all; straps reload at the first edge after it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // outputs straight from flops
   // link pulse
   assign link.sync_aligned    = s_q.aligned;
   // decoded configuration, stable between restarts
   assign filter_reset         = s_q.filt_rst;
   assign serial_ctrl          = s_q.serial;
   assign cfg                  = s_q.cfg;
   assign output_word_rate     = s_q.owr;
   assign notch_max_khz        = s_q.notch;
   assign notch_count          = s_q.ncount;
   assign serial_data_lanes    = s_q.lanes;
   assign output_bit_clock_div = s_q.bdiv;
   // strap control hides rate conversion and diagnostics
   assign rate_converter_en    = s_q.serial; // [RQ19]
   assign diag_en              = s_q.serial; // [RQ19]
endmodule : ssc_device

// ---- logic/ssc_host.sv ----
// host end: apb registers drive straps and restart pulses; start held low
`timescale 1ns/1ps
module ssc_host (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // link
   ssc_if.host              link
);
   import ssc_pkg::*;

   // all state
   typedef struct packed {
      logic [9:0]  strap;     // strap levels driven
      logic        restart;   // restart pulse
      logic [1:0]  al_sync;   // aligned pulse resync
      logic [15:0] count;     // aligned pulses seen
      logic [31:0] rdata;
      logic        ready;
      logic        err;
   } ssc_host_state_type;

   ssc_host_state_type s_q, s_d;

   // next state
   always_comb begin
      logic access;
      logic finish;
      s_d         = s_q;
      access      = psel & penable & ~s_q.ready;
      finish      = psel & penable & s_q.ready;
      s_d.ready   = access;
      s_d.err     = 1'b0;
      // board loop: every aligned pulse returns as a restart one clock later
      s_d.restart = link.sync_aligned; // [RQ6]
      s_d.al_sync = {s_q.al_sync[0], link.sync_aligned};
      // count aligned pulses seen on the link
      if (s_q.al_sync[1]) begin
         s_d.count   = s_q.count + 16'h0001;
      end
      // first access cycle: read data and error stand with pready
      if (access) begin
         s_d.rdata = 32'h0000_0000;
         unique case (paddr)
            SSC_REG_CTRL:   s_d.rdata = 32'h0000_0000;
            SSC_REG_STRAP:  s_d.rdata = {22'h00_0000, s_q.strap};
            SSC_REG_STATUS: s_d.rdata = {16'h0000, s_q.count};
            default:        s_d.err   = 1'b1;
         endcase
      end
      // a write lands only at the edge where pready is sampled high
      if (finish && pwrite) begin
         // bit0 issues one restart pulse after config changes
         if (paddr == SSC_REG_CTRL && pwdata[SSC_CTRL_TRIG_BIT])
            s_d.restart = 1'b1; // [RQ2]
         if (paddr == SSC_REG_STRAP)
            s_d.strap = pwdata[9:0];
      end
   end

   // state register; reset holds restart low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // link pins; start unused and held low
   assign link.start_async           = 1'b0;         // [RQ8]
   assign link.sync_restart          = s_q.restart;  // [RQ3] [RQ6]
   assign link.config_strap          = s_q.strap[SSC_ST_MODE_LSB +: 4];
   assign link.iface_format_strap_lo = s_q.strap[SSC_ST_FMT_LSB];
   assign link.iface_format_strap_hi = s_q.strap[SSC_ST_FMT_LSB + 1];
   assign link.aux_convert_strap     = s_q.strap[SSC_ST_AUX_BIT];
   assign link.divider_strap         = s_q.strap[SSC_ST_DIV_LSB +: 3];
   assign prdata  = s_q.rdata;
   assign pready  = s_q.ready;
   assign pslverr = s_q.err;
endmodule : ssc_host

// ---- verification/ssc_checker.sv ----
// link checker: pulse shapes, trigger cause, strap decode after restart
`timescale 1ns/1ps
module ssc_checker (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // link
   input  wire logic       start_async,
   input  wire logic       sync_restart,
   input  wire logic       sync_aligned,
   input  wire logic       iface_format_strap_lo,
   input  wire logic       iface_format_strap_hi,
   input  wire logic [2:0] divider_strap,
   // device side
   input  wire logic       ucfg2_wr,
   input  wire logic [7:0] ucfg2_wdata,
   input  wire logic       filter_reset,
   input  wire logic       serial_ctrl,
   input  wire logic [7:0] output_bit_clock_div,
   input  wire logic       rate_converter_en,
   input  wire logic       diag_en
);
   logic last_q;  // last trigger bit written, in any mode
   logic trig_q;  // a trigger was accepted one edge ago
   // mirror of the stored trigger bit; a toggle is only seen against it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_q <= 1'b0;
         trig_q <= 1'b0;
      end else begin
         last_q <= ucfg2_wr ? ucfg2_wdata[0] : last_q;
         trig_q <= ucfg2_wr && serial_ctrl && (ucfg2_wdata[0] != last_q);
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // accepted toggle of the trigger bit
   sequence s_trig;
      ucfg2_wr && serial_ctrl && (ucfg2_wdata[0] != last_q);
   endsequence
   // restart pulse arriving at the device
   sequence s_restart;
      $rose(sync_restart);
   endsequence
   a_aligned_single: assert property (
      sync_aligned |=> !sync_aligned) else $error("aligned pulse too long");
   a_trig_pulse: assert property (
      s_trig |=> sync_aligned) else $error("toggle gave no aligned pulse");
   a_aligned_cause: assert property (
      sync_aligned |-> trig_q) else $error("aligned pulse without cause");
   a_loop_restart: assert property (
      sync_aligned |=> sync_restart) else $error("aligned pulse not looped to restart");
   a_start_low: assert property (
      !start_async) else $error("unused start input not low");
   a_restart_single: assert property (
      sync_restart |=> !sync_restart) else $error("restart pulse too long");
   a_restart_reset: assert property (
      s_restart |-> ##[1:4] filter_reset) else $error("restart lost");
   a_serial_mode: assert property (
      filter_reset |=> serial_ctrl == (iface_format_strap_lo && iface_format_strap_hi))
      else $error("control mode wrong");
   a_div_pow2: assert property (
      filter_reset |=> output_bit_clock_div == (8'h01 << divider_strap))
      else $error("bit clock divider wrong");
   a_strap_locks: assert property (
      filter_reset |=> rate_converter_en == serial_ctrl && diag_en == serial_ctrl)
      else $error("strap mode features wrong");
endmodule : ssc_checker

// ---- verification/tb_top.sv ----
// testbench: host and device ends joined, driven over apb
`timescale 1ns/1ps
module tb_top;
   import ssc_pkg::*;
   logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0]   paddr, owr, nmax, e_owr;
   logic [31:0]   pwdata, prdata, rdat, w;
   logic          rerr, ucfg2_wr, filter_reset, serial_ctrl, rce, den;
   logic [7:0]    ucfg2_wdata, div;
   logic [2:0]    ncnt;
   ssc_cfg_type   cfg, e;       // seen and expected decode
   ssc_lanes_type lanes;
   int            bad_count, cmp_count, rst_count, n_rst;
   // decimation per strap code
   logic [8:0]    dec_t [16] = '{9'h010, 9'h010, 9'h020, 9'h020, 9'h040, 9'h040, 9'h080,
      9'h080, 9'h100, 9'h010, 9'h020, 9'h040, 9'h010, 9'h020, 9'h040, 9'h020};
   ssc_if lnk ();
   ssc_host i_ssc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(lnk.host));
   ssc_device i_ssc_device (.pclk(pclk), .presetn(presetn), .link(lnk.dev),
      .ucfg2_wr(ucfg2_wr), .ucfg2_wdata(ucfg2_wdata), .filter_reset(filter_reset),
      .serial_ctrl(serial_ctrl), .cfg(cfg), .output_word_rate(owr), .notch_max_khz(nmax),
      .notch_count(ncnt), .serial_data_lanes(lanes), .output_bit_clock_div(div),
      .rate_converter_en(rce), .diag_en(den));
   ssc_checker i_ssc_checker (.pclk(pclk), .presetn(presetn),
      .start_async(lnk.start_async), .sync_restart(lnk.sync_restart),
      .sync_aligned(lnk.sync_aligned), .iface_format_strap_lo(lnk.iface_format_strap_lo),
      .iface_format_strap_hi(lnk.iface_format_strap_hi), .divider_strap(lnk.divider_strap),
      .ucfg2_wr(ucfg2_wr), .ucfg2_wdata(ucfg2_wdata), .filter_reset(filter_reset),
      .serial_ctrl(serial_ctrl), .output_bit_clock_div(div), .rate_converter_en(rce),
      .diag_en(den));
   // compare and count
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // one apb transfer; waits for pready, counting access-phase cycles up to it
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no bound here: only the watchdog ends a hung transfer
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      chk(n, 32'h0000_0002);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // restart through the host control register, then wait for the filter reset
   task restart;
      int n;
      apb(1'b1, SSC_REG_CTRL, 32'h0000_0001);
      n = 0;
      while (filter_reset !== 1'b1 && n < 12) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, filter_reset}, 32'h0000_0001);
      repeat (2) @(posedge pclk);
   endtask : restart
   // write of the second setup register on the device
   task ucw(input logic b);
      @(posedge pclk);
      ucfg2_wr    <= 1'b1;
      ucfg2_wdata <= {7'h00, b};
      @(posedge pclk);
      ucfg2_wr    <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : ucw
   // verdict and end of run
   task stop_test;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   // filter resets seen, to follow the aligned-to-restart loop
   always @(posedge pclk) begin
      if (filter_reset === 1'b1) rst_count <= rst_count + 1;
   end
   // one clock shared by both ends
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #100000;
      bad_count++;
      stop_test();
   end
   // main sequence
   initial begin
      {psel, penable, pwrite, ucfg2_wr, presetn} = '0;
      {paddr, pwdata, ucfg2_wdata} = '0;
      bad_count = 0;
      cmp_count = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, SSC_REG_STRAP, 32'h0);
      chk(rdat, {22'h0, SSC_STRAP_RST});
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, rerr}, 32'h0000_0001);
      // every strap code, with lane layout and divider varied alongside
      for (int i = 0; i < 16; i++) begin
         w = {22'h0, i[2:0], 1'b0, 2'(i % 3), i[3:0]};
         apb(1'b1, SSC_REG_STRAP, w);
         restart();
         e = '{dec_t[i], i >= 12, i < 8 && i[0], i inside {9, 10, 11}, i < 14};
         chk({19'h0, cfg}, {19'h0, e});
         e_owr = ((i >= 12) ? SSC_LP_BASE_KHZ : SSC_HR_BASE_KHZ) / {3'h0, e.decimation};
         chk({20'h0, owr}, {20'h0, e_owr});
         if (e_owr > 12'(SSC_SINC5_REC_KSPS))
            chk({31'h0, cfg.sinc5}, 32'h0000_0001);
         chk({20'h0, nmax}, (i >= 12) ? 32'h0000_0020 : 32'h0000_0080);
         chk({29'h0, ncnt}, (i < 14) ? 32'h0000_0004 : 32'h0000_0002);
         chk({30'h0, lanes}, 32'(i % 3) + 32'h0000_0001);
         chk({24'h0, div}, 32'h0000_0001 << i[2:0]);
         apb(1'b0, SSC_REG_STRAP, 32'h0);
         chk(rdat, w);
         if (i == 0) ucw(1'b1); // stored only, no pulse outside serial control
      end
      apb(1'b1, SSC_REG_STRAP, 32'h0000_0040);
      restart();
      chk({30'h0, lanes}, {30'h0, SSC_LANES_SPI});
      apb(1'b1, SSC_REG_STRAP, 32'h0000_0030);
      restart();
      chk({29'h0, serial_ctrl, rce, den}, 32'h0000_0007);
      n_rst = rst_count;
      ucw(1'b0);
      ucw(1'b0);
      ucw(1'b1);
      apb(1'b0, SSC_REG_STATUS, 32'h0);
      chk(rdat & 32'h0000_ffff, 32'h0000_0002);
      chk(rst_count - n_rst, 32'h0000_0002);
      stop_test();
   end
endmodule : tb_top
